// ### hw/cat_top.sv
// counter array time base with five compare/capture modules on classic wishbone
`timescale 1ns/1ps
// Contract
// - one dedicated counter is the shared time base of five compare/capture modules.
// - counter source picked by two select bits among div6, div2, timer0 overflow, pin.
// - modules do edge capture, software timer, high-speed output or pwm.
// - module 4 can also act as a watchdog timer.
// - capture, software timer and high-speed output raise a module interrupt request.
// - all five module requests and counter overflow share one interrupt line.
// - counter input and modules 0 to 3 each own one port pin.
// - port pins unused by the array stay general-purpose I/O.
// - select 01 is clock div two, select 10 is timer 0 overflow.
// - the counter advances only while the run bit is set.
// - overflow sets a flag, interrupts if enabled, cleared only by software.
// - each module has its own flag, hardware set, software cleared, bit n.
module cat_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // count sources from the rest of the chip
  input  wire logic        timer0_ovf_i,
  // port pins: bit 0 external_count_input, bits 1..4 module0_pin..module3_pin
  input  wire logic [4:0]  port_in_i,
  output logic      [4:0]  port_out_o,
  output logic      [4:0]  port_oe_o,
  // watchdog reset request and interrupt
  output logic             wdt_rst_o,
  output logic             irq_o
);
  localparam int unsigned NM = cat_pkg::NUM_MOD;
  localparam int unsigned NP = cat_pkg::NUM_PIN;

  // configuration and status
  cat_pkg::cat_csel_t      csel_ff;
  logic                    wdt_en_ff;
  logic                    run_ff;
  logic [15:0]             count_ff;
  logic                    fresh_ff;
  logic [cat_pkg::FLAG_W-1:0] stat_ff;
  logic [cat_pkg::FLAG_W-1:0] ien_ff;
  cat_pkg::cat_mmode_t     mmode_ff [NM];
  logic [NP-1:0]           gpio_out_ff;
  logic [NP-1:0]           gpio_oe_ff;

  // bus
  logic                    ack_ff;
  logic [31:0]             rdat_ff;
  logic                    req;
  logic                    wr;
  logic [31:0]             wmask;
  logic [31:0]             rdat;

  // time base
  logic [2:0]              div6_ff;
  logic                    div2_ff;
  logic                    ext_s1_ff;
  logic                    ext_s2_ff;
  logic                    ext_s3_ff;
  logic                    div6_tick;
  logic                    ext_fall;
  logic                    src_tick;
  logic                    adv;
  logic                    ovf;
  logic                    cnt_we;
  cat_pkg::cat_tb_t        tb;

  // module side
  logic [NM-1:0]           mod_evt;
  logic [NM-1:0]           mod_pin;
  logic [NM-1:0]           mod_oe;
  logic [NM-1:0]           mod_wdt;
  logic [NM-1:0]           val_we;
  logic [15:0]             mod_val [NM];
  logic [cat_pkg::FLAG_W-1:0] flag_set;
  logic [cat_pkg::FLAG_W-1:0] flag_clr;
  logic [cat_pkg::FLAG_W-1:0] flag_keep;

  // wishbone: ack one cycle after the request, writes land on the ack edge
  assign req = wb_cyc_i & wb_stb_i;
  assign wr  = req & wb_we_i & ack_ff;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{wb_sel_i[b]}};
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] m,
                                        input logic [31:0] d);
    merge = (old_v & ~m) | (d & m);
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  always_comb begin
    rdat = 32'h0000_0000;
    unique case (wb_adr_i)
      cat_pkg::ADR_MODE: begin
        rdat[cat_pkg::CSEL_LSB +: 2]  = csel_ff;
        rdat[cat_pkg::WDT_EN_BIT]     = wdt_en_ff;
      end
      cat_pkg::ADR_CTRL: begin
        rdat[4:0]                     = stat_ff[4:0];
        rdat[cat_pkg::RUN_BIT]        = run_ff;
        rdat[cat_pkg::CTRL_OVF]       = stat_ff[cat_pkg::OVF_BIT];
      end
      cat_pkg::ADR_STAT:  rdat[cat_pkg::FLAG_W-1:0] = stat_ff;
      cat_pkg::ADR_IEN:   rdat[cat_pkg::FLAG_W-1:0] = ien_ff;
      cat_pkg::ADR_COUNT: rdat[15:0]                = count_ff;
      cat_pkg::ADR_GPIO: begin
        rdat[NP-1:0]                        = gpio_out_ff;
        rdat[cat_pkg::GPIO_OE_LSB +: NP]    = gpio_oe_ff;
        rdat[cat_pkg::GPIO_IN_LSB +: NP]    = port_in_i;
      end
      default: begin
        for (int m = 0; m < NM; m++) begin
          if (wb_adr_i == cat_pkg::ADR_MOD_BASE + 8'(m) * cat_pkg::ADR_MOD_STEP) begin
            rdat[2:0] = mmode_ff[m];
          end
          if (wb_adr_i == cat_pkg::ADR_MOD_BASE + 8'(m) * cat_pkg::ADR_MOD_STEP
                          + cat_pkg::ADR_MOD_VAL) begin
            rdat[15:0] = mod_val[m];
          end
        end
      end
    endcase
  end

  // read data is sampled with the request so it stands together with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= 32'h0000_0000;
    end else if (req & ~ack_ff) begin
      rdat_ff <= rdat;
    end
  end

  // control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      csel_ff   <= cat_pkg::CSEL_DIV6;
      wdt_en_ff <= 1'b0;
      run_ff    <= 1'b0;
      ien_ff    <= '0;
    end else if (wr) begin
      if (wb_adr_i == cat_pkg::ADR_MODE && wb_sel_i[0]) begin
        csel_ff   <= cat_pkg::cat_csel_t'(wb_dat_i[cat_pkg::CSEL_LSB +: 2]);
        wdt_en_ff <= wb_dat_i[cat_pkg::WDT_EN_BIT];
      end
      if (wb_adr_i == cat_pkg::ADR_CTRL && wb_sel_i[0]) begin
        run_ff <= wb_dat_i[cat_pkg::RUN_BIT];
      end
      if (wb_adr_i == cat_pkg::ADR_IEN && wb_sel_i[0]) begin
        ien_ff <= wb_dat_i[cat_pkg::FLAG_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int m = 0; m < NM; m++) begin
        mmode_ff[m] <= cat_pkg::MM_OFF;
      end
    end else if (wr && wb_sel_i[0]) begin
      for (int m = 0; m < NM; m++) begin
        if (wb_adr_i == cat_pkg::ADR_MOD_BASE + 8'(m) * cat_pkg::ADR_MOD_STEP) begin
          mmode_ff[m] <= cat_pkg::cat_mmode_t'(wb_dat_i[2:0]);
        end
      end
    end
  end

  always_comb begin
    for (int m = 0; m < NM; m++) begin
      val_we[m] = wr && (wb_sel_i[1:0] == 2'b11) &&
                  (wb_adr_i == cat_pkg::ADR_MOD_BASE + 8'(m) * cat_pkg::ADR_MOD_STEP
                               + cat_pkg::ADR_MOD_VAL);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpio_out_ff <= '0;
      gpio_oe_ff  <= '0;
    end else if (wr && wb_adr_i == cat_pkg::ADR_GPIO) begin
      gpio_out_ff <= NP'(merge(32'(gpio_out_ff), wmask, wb_dat_i));
      gpio_oe_ff  <= NP'(merge(32'(gpio_oe_ff), wmask >> cat_pkg::GPIO_OE_LSB,
                               wb_dat_i >> cat_pkg::GPIO_OE_LSB));
    end
  end

  // count sources
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div6_ff <= 3'h0;
      div2_ff <= 1'b0;
    end else begin
      div6_ff <= div6_tick ? 3'h0 : div6_ff + 3'h1;
      div2_ff <= ~div2_ff;
    end
  end

  assign div6_tick = div6_ff == cat_pkg::DIV_LAST;

  // the first stage feeds only the second; edges are found on later stages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
    end else begin
      ext_s1_ff <= port_in_i[0];
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
    end
  end

  assign ext_fall = ext_s3_ff & ~ext_s2_ff;

  always_comb begin
    unique case (csel_ff)
      cat_pkg::CSEL_DIV6: src_tick = div6_tick;
      cat_pkg::CSEL_DIV2: src_tick = div2_ff;
      cat_pkg::CSEL_T0:   src_tick = timer0_ovf_i;
      cat_pkg::CSEL_EXT:  src_tick = ext_fall;
    endcase
  end

  // time base counter; a software write to the count wins over a tick
  assign adv    = run_ff & src_tick;
  assign ovf    = adv & (count_ff == 16'hffff) & ~cnt_we;
  assign cnt_we = wr && wb_adr_i == cat_pkg::ADR_COUNT;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_ff <= cat_pkg::COUNT_RST;
      fresh_ff <= 1'b0;
    end else begin
      fresh_ff <= adv | cnt_we;
      if (cnt_we) begin
        count_ff <= 16'(merge(32'(count_ff), wmask, wb_dat_i));
      end else if (adv) begin
        count_ff <= count_ff + 16'h0001;
      end
    end
  end

  assign tb.count = count_ff;
  assign tb.fresh = fresh_ff;

  // compare/capture modules
  for (genvar m = 0; m < NM; m++) begin : g_mod
    cat_ccm #(
      .HAS_WDT (m == cat_pkg::WDT_MOD)
    ) u_ccm (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .tb_i       (tb),
      .mode_i     (mmode_ff[m]),
      .wdt_en_i   (wdt_en_ff),
      .val_we_i   (val_we[m]),
      .val_wdat_i (wb_dat_i[15:0]),
      .val_o      (mod_val[m]),
      .pin_i      ((m < NP - 1) ? port_in_i[(m + 1) % NP] : 1'b0),
      .event_o    (mod_evt[m]),
      .pin_o      (mod_pin[m]),
      .pin_oe_o   (mod_oe[m]),
      .wdt_rst_o  (mod_wdt[m])
    );
  end

  // flags and interrupt: a set in the clear cycle is kept
  assign flag_set  = {ovf, mod_evt};
  assign flag_clr  = (wr && wb_adr_i == cat_pkg::ADR_CLR && wb_sel_i[0]) ?
                     wb_dat_i[cat_pkg::FLAG_W-1:0] : '0;
  assign flag_keep = stat_ff & ~flag_clr;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= flag_keep | flag_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o     <= 1'b0;
      wdt_rst_o <= 1'b0;
    end else begin
      irq_o     <= |(stat_ff & ien_ff);
      wdt_rst_o <= |mod_wdt;
    end
  end

  // port pins: a module that drives its pin takes it from the gpio latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_out_o <= '0;
      port_oe_o  <= '0;
    end else begin
      port_out_o[0] <= gpio_out_ff[0];
      port_oe_o[0]  <= gpio_oe_ff[0];
      for (int k = 1; k < NP; k++) begin
        port_out_o[k] <= mod_oe[k-1] ? mod_pin[k-1] : gpio_out_ff[k];
        port_oe_o[k]  <= mod_oe[k-1] | gpio_oe_ff[k];
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  count_wrap_a: assert property ((count_ff == 16'hffff) && adv && !cnt_we
    |=> (count_ff == 16'h0000) && stat_ff[cat_pkg::OVF_BIT])
    else $error("counter did not wrap with overflow flag");
  run_hold_a: assert property (!run_ff && !cnt_we |=> $stable(count_ff))
    else $error("counter moved while stopped");
  div6_gap_a: assert property (div6_tick |=> !div6_tick [*5] ##1 div6_tick)
    else $error("slow prescaler period is not six");
  div2_sel_a: assert property (run_ff && csel_ff == cat_pkg::CSEL_DIV2 && !cnt_we
    |=> count_ff == $past(count_ff) + 16'($past(div2_ff)))
    else $error("div two source not followed");
  t0_sel_a: assert property (run_ff && csel_ff == cat_pkg::CSEL_T0 && !cnt_we
    |=> count_ff == $past(count_ff) + 16'($past(timer0_ovf_i)))
    else $error("timer 0 overflow source not followed");
  ext_edge_a: assert property ($fell(ext_s2_ff) && run_ff &&
    csel_ff == cat_pkg::CSEL_EXT && !cnt_we |=> count_ff == $past(count_ff) + 16'h0001
    ##1 count_ff == $past(count_ff))
    else $error("external edge did not count exactly once");
  flag_sticky_a: assert property (1'b1 |=> (stat_ff & $past(flag_keep)) ==
    $past(flag_keep))
    else $error("flag dropped without software clear");
  flag_set_a: assert property (|mod_evt |=> (stat_ff[4:0] & $past(mod_evt)) ==
    $past(mod_evt))
    else $error("module event lost");
  irq_level_a: assert property (##1 irq_o == $past(|(stat_ff & ien_ff)))
    else $error("interrupt line does not follow enabled flags");
  wdt_only4_a: assert property (wdt_rst_o |-> $past(mod_wdt[cat_pkg::WDT_MOD])
    && $past(wdt_en_ff))
    else $error("watchdog reset without module 4 watchdog");
  gpio_pass_a: assert property (!mod_oe[0] |=> port_oe_o[1] == $past(gpio_oe_ff[1])
    && port_out_o[1] == $past(gpio_out_ff[1]))
    else $error("free pin not given to general I/O");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  ovf_seen_c: cover property (adv && count_ff == 16'hffff);
  cap_seen_c: cover property (mod_evt[0] && mmode_ff[0] == cat_pkg::MM_CAP_B);
  wdt_seen_c: cover property (wdt_rst_o);
  irq_seen_c: cover property (irq_o ##1 !irq_o);
endmodule

// ### hw/cat_pkg.sv
// package: constants and types of the counter array time base
package cat_pkg;
  localparam int unsigned NUM_MOD     = 5;
  localparam int unsigned NUM_PIN     = 5;
  localparam int unsigned FLAG_W      = 6;
  localparam int unsigned OVF_BIT     = 5;
  localparam int unsigned WDT_MOD     = 4;

  // register byte offsets
  localparam logic [7:0] ADR_MODE     = 8'h00;
  localparam logic [7:0] ADR_CTRL     = 8'h04;
  localparam logic [7:0] ADR_STAT     = 8'h08;
  localparam logic [7:0] ADR_CLR      = 8'h0c;
  localparam logic [7:0] ADR_IEN      = 8'h10;
  localparam logic [7:0] ADR_COUNT    = 8'h14;
  localparam logic [7:0] ADR_GPIO     = 8'h18;
  localparam logic [7:0] ADR_MOD_BASE = 8'h20;
  localparam logic [7:0] ADR_MOD_STEP = 8'h08;
  localparam logic [7:0] ADR_MOD_VAL  = 8'h04;

  // field positions
  localparam int unsigned CSEL_LSB    = 1;
  localparam int unsigned WDT_EN_BIT  = 6;
  localparam int unsigned RUN_BIT     = 6;
  localparam int unsigned CTRL_OVF    = 7;
  localparam int unsigned GPIO_OE_LSB = 8;
  localparam int unsigned GPIO_IN_LSB = 16;

  // reset values
  localparam logic [15:0] COUNT_RST   = 16'h0000;
  localparam logic [15:0] VAL_RST     = 16'h0000;

  // slow prescaler: divide by six, last count of the divider
  localparam int unsigned DIV_SLOW    = 6;
  localparam logic [2:0]  DIV_LAST    = 3'(DIV_SLOW - 1);

  typedef enum logic [1:0] {
    CSEL_DIV6 = 2'b00,
    CSEL_DIV2 = 2'b01,
    CSEL_T0   = 2'b10,
    CSEL_EXT  = 2'b11
  } cat_csel_t;

  typedef enum logic [2:0] {
    MM_OFF   = 3'b000,
    MM_CAP_R = 3'b001,
    MM_CAP_F = 3'b010,
    MM_CAP_B = 3'b011,
    MM_SWT   = 3'b100,
    MM_HSO   = 3'b101,
    MM_PWM   = 3'b110,
    MM_WDT   = 3'b111
  } cat_mmode_t;

  // shared time base as seen by every module
  typedef struct packed {
    logic [15:0] count;
    logic        fresh;
  } cat_tb_t;
endpackage

// ### hw/cat_ccm.sv
// one compare/capture module driven by the shared time base
`timescale 1ns/1ps
module cat_ccm #(
  parameter bit HAS_WDT = 1'b0
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // time base and configuration
  input  wire cat_pkg::cat_tb_t    tb_i,
  input  wire cat_pkg::cat_mmode_t mode_i,
  input  wire logic                wdt_en_i,
  // value register access
  input  wire logic                val_we_i,
  input  wire logic [15:0]         val_wdat_i,
  output logic      [15:0]         val_o,
  // events and pin
  input  wire logic                pin_i,
  output logic                     event_o,
  output logic                     pin_o,
  output logic                     pin_oe_o,
  output logic                     wdt_rst_o
);
  logic [15:0] val_ff;
  logic        pin_d_ff;
  logic        pin_ff;
  logic        rise;
  logic        fall;
  logic        match;
  logic        cap;

  assign rise  = pin_i & ~pin_d_ff;
  assign fall  = ~pin_i & pin_d_ff;
  assign match = tb_i.fresh && (tb_i.count == val_ff);

  always_comb begin
    cap       = 1'b0;
    event_o   = 1'b0;
    pin_oe_o  = 1'b0;
    wdt_rst_o = 1'b0;
    unique case (mode_i)
      cat_pkg::MM_OFF:   cap = 1'b0;
      cat_pkg::MM_CAP_R: cap = rise;
      cat_pkg::MM_CAP_F: cap = fall;
      cat_pkg::MM_CAP_B: cap = rise | fall;
      cat_pkg::MM_SWT:   event_o = match;
      cat_pkg::MM_HSO: begin
        event_o  = match;
        pin_oe_o = 1'b1;
      end
      cat_pkg::MM_PWM:   pin_oe_o = 1'b1;
      cat_pkg::MM_WDT: begin
        // a module without watchdog support treats this code as off
        wdt_rst_o = HAS_WDT && wdt_en_i && match;
      end
    endcase
    if (cap) begin
      event_o = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_d_ff <= 1'b0;
    end else begin
      pin_d_ff <= pin_i;
    end
  end

  // software write wins over a capture in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      val_ff <= cat_pkg::VAL_RST;
    end else if (val_we_i) begin
      val_ff <= val_wdat_i;
    end else if (cap) begin
      val_ff <= tb_i.count;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_ff <= 1'b0;
    end else if (mode_i == cat_pkg::MM_HSO && match) begin
      pin_ff <= ~pin_ff;
    end else if (mode_i == cat_pkg::MM_PWM) begin
      // low while the low count byte is below the duty value
      pin_ff <= tb_i.count[7:0] >= val_ff[7:0];
    end
  end

  assign val_o = val_ff;
  assign pin_o = pin_ff;
endmodule

// ### tb/cat_pin_model.sv
// far-side model of the port pins: external count source and module pin drivers
`timescale 1ns/1ps
module cat_pin_model (
  // clock
  input  wire logic       clk_i,
  // design drive
  input  wire logic [4:0] out_i,
  input  wire logic [4:0] oe_i,
  // resolved pin levels
  output logic      [4:0] pin_o
);
  logic [4:0] drv_ff = 5'h01;

  // a pin the design drives shows its value, otherwise the far side's level
  assign pin_o = (oe_i & out_i) | (~oe_i & drv_ff);

  task automatic set_pin(input int k, input logic v);
    drv_ff[k] <= v;
    @(posedge clk_i);
  endtask

  // three cycles per phase so the two-flop synchroniser cannot miss an edge
  task automatic ext_pulses(input int k);
    repeat (k) begin
      drv_ff[0] <= 1'b0;
      repeat (3) @(posedge clk_i);
      drv_ff[0] <= 1'b1;
      repeat (3) @(posedge clk_i);
    end
  endtask
endmodule

// ### tb/tb_top.sv
// self-checking bench of the counter array time base
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    logic [31:0] m;
    int          lo;
    int          hi;
  } cat_exp_t;

  localparam logic [31:0] SEL_T0 = 32'(cat_pkg::CSEL_T0) << cat_pkg::CSEL_LSB;
  localparam logic [31:0] RUN    = 32'h1 << cat_pkg::RUN_BIT;
  localparam logic [31:0] ALL    = 32'hffffffff;

  logic        clk_i        = 1'b0;
  logic        rst_i        = 1'b1;
  logic        wb_cyc_i     = 1'b0;
  logic        wb_stb_i     = 1'b0;
  logic        wb_we_i      = 1'b0;
  logic [7:0]  wb_adr_i     = 8'h00;
  logic [3:0]  wb_sel_i     = 4'hf;
  logic [31:0] wb_dat_i     = 32'h0;
  logic        timer0_ovf_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        wdt_rst_o;
  logic        irq_o;
  logic [4:0]  port_in_i;
  logic [4:0]  port_out_o;
  logic [4:0]  port_oe_o;
  int          fail_count   = 0;
  int          check_count  = 0;
  int          wdt_seen     = 0;
  int          seed         = 32'h8f5df916;
  int          k;
  cat_exp_t    exp_q[$];
  cat_exp_t    rec;
  logic [31:0] r;
  logic [15:0] v;
  logic [15:0] pw[3]        = '{16'h007f, 16'h0180, 16'h0010};

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  cat_top u_cat_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer0_ovf_i(timer0_ovf_i),
    .port_in_i(port_in_i), .port_out_o(port_out_o), .port_oe_o(port_oe_o),
    .wdt_rst_o(wdt_rst_o), .irq_o(irq_o)
  );

  cat_pin_model u_cat_pin_model (
    .clk_i(clk_i), .out_i(port_out_o), .oe_i(port_oe_o), .pin_o(port_in_i)
  );

  task automatic report(input string s);
    fail_count++;
    $display("unexpected at %0t: %s", $time, s);
  endtask

  task automatic check(input logic got, input logic exp, input string s);
    check_count++;
    if (got !== exp) report(s);
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one classic cycle; the request stands until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] m, input int lo, input int hi);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    if (!we) exp_q.push_back('{m, lo, hi});
    // no limit here: a bus that never answers is caught by the watchdog
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 32'h0, 0, 0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input int e);
    wb(1'b0, a, 32'h0, m, e, e);
  endtask

  // write with chosen byte lanes; lanes go back to all-on once the cycle ends
  task automatic wrs(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    wb_sel_i <= s;
    wb(1'b1, a, d, 32'h0, 0, 0);
    wb_sel_i <= 4'hf;
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      timer0_ovf_i <= 1'b1;
      @(posedge clk_i);
      timer0_ovf_i <= 1'b0;
      @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
  endtask

  function automatic logic [7:0] madr(input int n, input bit val);
    return 8'(cat_pkg::ADR_MOD_BASE + cat_pkg::ADR_MOD_STEP * n + (val ? 4 : 0));
  endfunction

  // read results are matched against the oldest note in issue order
  always @(posedge clk_i) begin
    if (wdt_rst_o === 1'b1) wdt_seen++;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      check_count++;
      if (exp_q.size() == 0) begin
        report("read answer without a note");
      end else begin
        rec = exp_q.pop_front();
        r = wb_dat_o & rec.m;
        if ($isunknown(r) || r < rec.lo || r > rec.hi) report($sformatf("read %h", r));
      end
    end
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(cat_pkg::ADR_MODE, ALL, 0);
    rd(cat_pkg::ADR_CTRL, ALL, 0);
    rd(cat_pkg::ADR_STAT, ALL, 0);
    rd(cat_pkg::ADR_COUNT, ALL, 0);
    rd(cat_pkg::ADR_GPIO, ALL, 32'h10000);
    rd(8'h1c, ALL, 0);
    // the prescalers free-run, so their phase leaves a count of slack
    for (int s = 0; s < 2; s++) begin
      wr(cat_pkg::ADR_COUNT, 32'h0);
      wr(cat_pkg::ADR_MODE, 32'(s) << cat_pkg::CSEL_LSB);
      wr(cat_pkg::ADR_CTRL, RUN);
      repeat (60) @(posedge clk_i);
      wr(cat_pkg::ADR_CTRL, 32'h0);
      wb(1'b0, cat_pkg::ADR_COUNT, 0, 32'hffff, s ? 30 : 9, s ? 33 : 12);
    end
    for (int s = 2; s < 4; s++) begin
      k = 1 + {$random(seed)} % 20;
      wr(cat_pkg::ADR_COUNT, 32'h0);
      wr(cat_pkg::ADR_MODE, 32'(s) << cat_pkg::CSEL_LSB);
      wr(cat_pkg::ADR_CTRL, RUN);
      if (s == 2) tick(k);
      else u_cat_pin_model.ext_pulses(k);
      repeat (4) @(posedge clk_i);
      rd(cat_pkg::ADR_COUNT, 32'hffff, k);
      wr(cat_pkg::ADR_CTRL, 32'h0);
      if (s == 2) tick(3);
      else u_cat_pin_model.ext_pulses(3);
      rd(cat_pkg::ADR_COUNT, 32'hffff, k);
    end
    wr(cat_pkg::ADR_MODE, SEL_T0);
    wr(cat_pkg::ADR_COUNT, 32'hfffe);
    wr(cat_pkg::ADR_CTRL, RUN);
    tick(1);
    rd(cat_pkg::ADR_STAT, 32'h3f, 0);
    tick(1);
    rd(cat_pkg::ADR_COUNT, 32'hffff, 0);
    rd(cat_pkg::ADR_CTRL, 32'h80, 32'h80);
    check(irq_o, 1'b0, "overflow irq while disabled");
    wr(cat_pkg::ADR_IEN, 32'h20);
    @(posedge clk_i);
    check(irq_o, 1'b1, "overflow irq missing");
    wr(cat_pkg::ADR_STAT, 32'h0);
    rd(cat_pkg::ADR_STAT, 32'h3f, 32'h20);
    wr(cat_pkg::ADR_CLR, 32'h20);
    rd(cat_pkg::ADR_STAT, 32'h3f, 0);
    check(irq_o, 1'b0, "irq after clear");
    // odd modules use high-speed output so their pins toggle as well
    for (int n = 0; n < 5; n++) begin
      v = 16'(1 + {$random(seed)} % 32'hfff0);
      wr(cat_pkg::ADR_IEN, 32'h1 << n);
      wr(madr(n, 0), 32'(n % 2 ? cat_pkg::MM_HSO : cat_pkg::MM_SWT));
      wr(madr(n, 1), {16'h0, v});
      wr(cat_pkg::ADR_COUNT, {16'h0, v - 16'h1});
      tick(1);
      rd(cat_pkg::ADR_STAT, 32'h1f, 1 << n);
      check(irq_o, 1'b1, "module irq missing");
      if (n % 2) begin
        rd(cat_pkg::ADR_GPIO, 32'h1 << (17 + n), 1 << (17 + n));
        check(port_oe_o[n + 1], 1'b1, "output pin not driven");
      end
      wr(cat_pkg::ADR_IEN, 32'h0);
      @(posedge clk_i);
      check(irq_o, 1'b0, "masked module irq");
      wr(cat_pkg::ADR_CLR, 32'h1 << n);
      wr(madr(n, 0), 32'h0);
    end
    for (int w = 0; w < 2; w++) begin
      wr(cat_pkg::ADR_MODE, SEL_T0 | (32'(w) << cat_pkg::WDT_EN_BIT));
      wr(madr(4, 0), 32'(cat_pkg::MM_WDT));
      wr(madr(4, 1), 32'h0100);
      wr(cat_pkg::ADR_COUNT, 32'h00ff);
      tick(1);
      check(wdt_seen == w, 1'b1, "watchdog reset count");
    end
    wr(madr(4, 0), 32'h0);
    wr(cat_pkg::ADR_CLR, 32'h3f);
    // counter held still so a capture must return this exact count
    wr(cat_pkg::ADR_CTRL, 32'h0);
    wr(cat_pkg::ADR_COUNT, 32'h1234);
    for (int m = 1; m < 4; m++) begin
      wr(madr(1, 0), 32'(m));
      wr(madr(1, 1), 32'h0);
      u_cat_pin_model.set_pin(2, 1'b1);
      repeat (4) @(posedge clk_i);
      rd(cat_pkg::ADR_STAT, 32'h2, m != 2 ? 2 : 0);
      rd(madr(1, 1), 32'hffff, m != 2 ? 32'h1234 : 0);
      wr(cat_pkg::ADR_CLR, 32'h2);
      u_cat_pin_model.set_pin(2, 1'b0);
      repeat (4) @(posedge clk_i);
      rd(cat_pkg::ADR_STAT, 32'h2, m != 1 ? 2 : 0);
      wr(cat_pkg::ADR_CLR, 32'h2);
    end
    // only the low byte lane lands, the high byte of the count is kept
    wrs(cat_pkg::ADR_COUNT, 32'hffff_ff56, 4'h1);
    rd(cat_pkg::ADR_COUNT, 32'hffff, 32'h1256);
    wr(madr(2, 1), 32'h80);
    wr(madr(2, 0), 32'(cat_pkg::MM_PWM));
    for (int i = 0; i < 3; i++) begin
      wr(cat_pkg::ADR_COUNT, {16'h0, pw[i]});
      // the pwm level needs a module flop and a port flop to reach the pin
      repeat (2) @(posedge clk_i);
      rd(cat_pkg::ADR_GPIO, 32'h80000, pw[i][7:0] >= 8'h80 ? 32'h80000 : 0);
    end
    wr(cat_pkg::ADR_GPIO, 32'h0100);
    rd(cat_pkg::ADR_GPIO, 32'h10101, 32'h100);
    check(port_oe_o[0], 1'b1, "general pin not driven");
    tally_and_finish();
  end

  initial begin
    repeat (30000) @(posedge clk_i);
    report("run did not finish");
    tally_and_finish();
  end
endmodule
